/* rtl/lcce_exec.sv */
// execution unit for conjunction, call, clear, complement and watchdog clear instructions

module lcce_exec (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic clk_en,
    input wire logic [lcce_pkg::AVS_AW-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic exec_busy
);
    import lcce_pkg::*;

    // ****************************************
    // decode helpers
    // ****************************************
    // true for the instructions that write a data memory byte
    function automatic logic writes_mem(input lcce_op_t op);
        writes_mem = (op == OP_CONJ_INTO_MEMORY) || (op == OP_CLEAR_MEM)
            || (op == OP_CLEAR_BIT) || (op == OP_INVERT_MEMORY_BYTE);
    endfunction : writes_mem

    // merge a bus word into an old value under the byte enables
    function automatic logic [31:0] merge_be(input logic [31:0] old_v, input logic [31:0] new_v,
                                             input logic [3:0] be);
        logic [31:0] r;
        for (int i = 0; i < 4; i++)
        begin
            r[i*8 +: 8] = be[i] ? new_v[i*8 +: 8] : old_v[i*8 +: 8];
        end
        merge_be = r;
    endfunction : merge_be

    localparam logic [3:0] ICYC = 4'(CLKS_PER_INSTR_CYCLE);

    // ****************************************
    // state
    // ****************************************
    logic [7:0] mem_q [MEM_WORDS];
    logic [PC_W-1:0] stack_q [STACK_DEPTH];
    logic [7:0] acc_q, acc_d;
    logic zero_q, zero_d, timeout_q, timeout_d, powerdown_q, powerdown_d;
    logic [PC_W-1:0] pc_q, pc_d;
    logic [SP_W-1:0] sp_q, sp_d;
    logic [7:0] wdt_q, wdt_d;
    logic [1:0] tick_q, tick_d;
    lcce_pre_t pre_q, pre_d;
    logic [3:0] op_q, op_d;
    logic [2:0] bit_q, bit_d;
    logic [PC_W-1:0] operand_q, operand_d;
    logic [3:0] cnt_q, cnt_d;
    logic busy_q, busy_d, wait_q, wait_d;
    logic [31:0] rdata_q, rdata_d;
    // combinational nets
    logic mem_we, stack_we, bus_take, bus_wr, bus_rd, commit, wdt_clear, is_mem_window;
    logic [MEM_AW-1:0] mem_wa, mem_addr, win_addr;
    logic [7:0] mem_wd, mem_rd, mem_res, acc_res;
    lcce_op_t cur_op, new_op;

    // ****************************************
    // bus handshake
    // ****************************************
    // one wait cycle per request: waitrequest drops for the edge that completes it
    always_comb
    begin
        wait_d = !((avs_read || avs_write) && wait_q);
    end

    assign bus_take = (avs_read || avs_write) && !wait_q;
    assign bus_wr = bus_take && avs_write;
    assign bus_rd = avs_read && wait_q;
    // compared one bit wider, since a full 64-word bound would wrap to zero in six bits
    assign is_mem_window = (avs_address[8] == OFS_MEM_BASE[8]) && (avs_address[1:0] == 2'b00)
        && (7'(avs_address[7:2]) < 7'(MEM_WORDS));
    assign win_addr = avs_address[MEM_AW+1:2];

    // ****************************************
    // instruction datapath
    // ****************************************
    assign cur_op = lcce_op_t'(op_q);
    assign new_op = lcce_op_t'(avs_writedata[CMD_OP_LSB +: 4]);
    assign mem_addr = operand_q[MEM_AW-1:0];
    // the low program counter byte sits in the memory space, so reads see it live
    assign mem_rd = (mem_addr == PCL_MEM_ADDR) ? pc_q[7:0] : mem_q[mem_addr];
    assign commit = busy_q && (cnt_q == 4'h0);
    assign acc_res = (cur_op == OP_CONJ_ACC_IMM) ? (acc_q & operand_q[7:0])
                                                 : (acc_q & mem_rd);

    // memory result for each writing instruction
    always_comb
    begin
        mem_res = mem_rd;
        case (cur_op)
            OP_CONJ_INTO_MEMORY: mem_res = acc_q & mem_rd;
            OP_CLEAR_MEM: mem_res = 8'h00;
            OP_CLEAR_BIT: mem_res = mem_rd & ~(8'h01 << bit_q);
            OP_INVERT_MEMORY_BYTE: mem_res = ~mem_rd;
            default: mem_res = mem_rd;
        endcase
    end

    // watchdog clear decision, pairing the two preclears
    always_comb
    begin
        wdt_clear = 1'b0;
        pre_d = pre_q;
        if (commit)
        begin
            pre_d = PRE_NONE;
            case (cur_op)
                OP_WATCHDOG_SINGLE_CLEAR: wdt_clear = 1'b1;
                OP_WATCHDOG_PRECLEAR_FIRST:
                begin
                    wdt_clear = (pre_q == PRE_SECOND);
                    pre_d = wdt_clear ? PRE_NONE : PRE_FIRST;
                end
                OP_WATCHDOG_PRECLEAR_SECOND:
                begin
                    wdt_clear = (pre_q == PRE_FIRST);
                    pre_d = wdt_clear ? PRE_NONE : PRE_SECOND;
                end
                default: wdt_clear = 1'b0;
            endcase
        end
    end

    // ****************************************
    // sequencing, registers and memory writes
    // ****************************************
    // command issue, cycle count, commit of results and register writes
    always_comb
    begin
        acc_d = acc_q;
        zero_d = zero_q;
        pc_d = pc_q;
        sp_d = sp_q;
        op_d = op_q;
        bit_d = bit_q;
        operand_d = operand_q;
        cnt_d = cnt_q;
        busy_d = busy_q;
        powerdown_d = powerdown_q;
        mem_we = 1'b0;
        mem_wa = mem_addr;
        mem_wd = mem_res;
        stack_we = 1'b0;
        if (busy_q && (cnt_q != 4'h0))
        begin
            cnt_d = cnt_q - 4'h1;
        end
        if (commit)
        begin
            busy_d = 1'b0;
            pc_d = pc_q + 11'h001;
            case (cur_op)
                OP_CONJ_ACC_MEM, OP_CONJ_ACC_IMM:
                begin
                    acc_d = acc_res;
                    zero_d = (acc_res == 8'h00);
                end
                OP_CONJ_INTO_MEMORY, OP_INVERT_MEMORY_BYTE:
                begin
                    zero_d = (mem_res == 8'h00);
                end
                OP_CALL:
                begin
                    stack_we = 1'b1;
                    sp_d = sp_q + 2'b01;
                    pc_d = operand_q;
                end
                default: zero_d = zero_q;
            endcase
            if (writes_mem(cur_op))
            begin
                if (mem_addr == PCL_MEM_ADDR)
                begin
                    pc_d = {pc_q[PC_W-1:8], mem_res};
                end
                else
                begin
                    mem_we = 1'b1;
                end
            end
        end
        // a command arriving while busy is dropped
        if (bus_wr && !busy_q && (avs_address == OFS_COMMAND) && avs_byteenable[0])
        begin
            op_d = new_op;
            bit_d = avs_writedata[CMD_BIT_LSB +: 3];
            busy_d = 1'b1;
            if (new_op == OP_CALL)
            begin
                cnt_d = 4'(CALL_CYCLES) * ICYC - 4'h1;
            end
            else if (writes_mem(new_op) && (operand_q[MEM_AW-1:0] == PCL_MEM_ADDR))
            begin
                cnt_d = 4'(PLAIN_CYCLES + PCL_PENALTY_CYCLES) * ICYC - 4'h1;
            end
            else
            begin
                cnt_d = 4'(PLAIN_CYCLES) * ICYC - 4'h1;
            end
        end
        if (bus_wr && !busy_q)
        begin
            if (avs_address == OFS_OPERAND)
            begin
                operand_d = PC_W'(merge_be(32'(operand_q), avs_writedata, avs_byteenable));
            end
            if ((avs_address == OFS_ACC) && avs_byteenable[0])
            begin
                acc_d = avs_writedata[7:0];
            end
            if (is_mem_window && avs_byteenable[0])
            begin
                mem_we = 1'b1;
                mem_wa = win_addr;
                mem_wd = avs_writedata[7:0];
            end
        end
        // software may raise powerdown to mimic entry to sleep; a clear wins only if no set
        if (wdt_clear)
        begin
            powerdown_d = 1'b0;
        end
        if (bus_wr && (avs_address == OFS_STATUS) && avs_byteenable[0]
            && avs_writedata[ST_POWERDOWN_BIT])
        begin
            powerdown_d = 1'b1;
        end
    end

    // watchdog counter, ticking once per instruction cycle
    always_comb
    begin
        tick_d = tick_q + 2'b01;
        wdt_d = wdt_q;
        timeout_d = timeout_q;
        if (tick_q == 2'b11)
        begin
            wdt_d = wdt_q + 8'h01;
        end
        if (wdt_clear)
        begin
            wdt_d = WATCHDOG_RST;
            tick_d = 2'b00;
            timeout_d = 1'b0;
        end
        // an overflow in the clearing cycle still sets the flag
        if ((tick_q == 2'b11) && (wdt_q == 8'hff))
        begin
            timeout_d = 1'b1;
        end
    end

    // read mux; unmapped addresses read zero
    always_comb
    begin
        rdata_d = rdata_q;
        if (bus_rd)
        begin
            rdata_d = 32'h0000_0000;
            case (avs_address)
                OFS_COMMAND: rdata_d[7:0] = {1'b0, bit_q, op_q};
                OFS_OPERAND: rdata_d[PC_W-1:0] = operand_q;
                OFS_ACC: rdata_d[7:0] = acc_q;
                OFS_STATUS: rdata_d[3:0] = {busy_q, powerdown_q, timeout_q, zero_q};
                OFS_PC: rdata_d[PC_W-1:0] = pc_q;
                OFS_WATCHDOG: rdata_d[7:0] = wdt_q;
                OFS_STACK_PTR: rdata_d[SP_W-1:0] = sp_q;
                OFS_STACK_TOP: rdata_d[PC_W-1:0] = stack_q[sp_q - 2'b01];
                default:
                begin
                    if (is_mem_window)
                    begin
                        rdata_d[7:0] = (win_addr == PCL_MEM_ADDR) ? pc_q[7:0] : mem_q[win_addr];
                    end
                end
            endcase
        end
    end

    // register stage for all control state
    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            acc_q <= ACC_RST;
            zero_q <= 1'b0;
            timeout_q <= 1'b0;
            powerdown_q <= 1'b0;
            pc_q <= PC_RST;
            sp_q <= '0;
            wdt_q <= WATCHDOG_RST;
            tick_q <= 2'b00;
            pre_q <= PRE_NONE;
            op_q <= 4'h0;
            bit_q <= 3'h0;
            operand_q <= '0;
            cnt_q <= 4'h0;
            busy_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            wait_q <= 1'b1;
        end
        else if (clk_en)
        begin
            acc_q <= acc_d;
            zero_q <= zero_d;
            timeout_q <= timeout_d;
            powerdown_q <= powerdown_d;
            pc_q <= pc_d;
            sp_q <= sp_d;
            wdt_q <= wdt_d;
            tick_q <= tick_d;
            pre_q <= pre_d;
            op_q <= op_d;
            bit_q <= bit_d;
            operand_q <= operand_d;
            cnt_q <= cnt_d;
            busy_q <= busy_d;
            rdata_q <= rdata_d;
            wait_q <= wait_d;
        end
    end

    // memory and stack arrays; contents are not reset, only their pointers
    always_ff @(posedge core_clk)
    begin
        if (clk_en && !reset)
        begin
            if (mem_we)
            begin
                mem_q[mem_wa] <= mem_wd;
            end
            if (stack_we)
            begin
                stack_q[sp_q] <= pc_q + 11'h001;
            end
        end
    end

    assign avs_readdata = rdata_q;
    assign avs_waitrequest = wait_q;
    assign exec_busy = busy_q;

endmodule : lcce_exec

/* rtl/lcce_pkg.sv */
// constants, register map and instruction codes of the logic/call/clear execution unit
package lcce_pkg;

    // ****************************************
    // geometry
    // ****************************************
    localparam int unsigned PC_W = 11;
    localparam int unsigned MEM_AW = 6;
    localparam int unsigned MEM_WORDS = 64;
    localparam int unsigned STACK_DEPTH = 4;
    localparam int unsigned SP_W = 2;
    localparam int unsigned AVS_AW = 9;

    // ****************************************
    // timing
    // ****************************************
    localparam int unsigned CLKS_PER_INSTR_CYCLE = 4;
    localparam int unsigned CALL_CYCLES = 2;
    localparam int unsigned PLAIN_CYCLES = 1;
    localparam int unsigned PCL_PENALTY_CYCLES = 1;

    // ****************************************
    // register byte offsets
    // ****************************************
    localparam logic [8:0] OFS_COMMAND = 9'h000;
    localparam logic [8:0] OFS_OPERAND = 9'h004;
    localparam logic [8:0] OFS_ACC = 9'h008;
    localparam logic [8:0] OFS_STATUS = 9'h00c;
    localparam logic [8:0] OFS_PC = 9'h010;
    localparam logic [8:0] OFS_WATCHDOG = 9'h014;
    localparam logic [8:0] OFS_STACK_PTR = 9'h018;
    localparam logic [8:0] OFS_STACK_TOP = 9'h01c;
    localparam logic [8:0] OFS_MEM_BASE = 9'h100;

    // data memory address that aliases the program counter low byte
    localparam logic [MEM_AW-1:0] PCL_MEM_ADDR = 6'h02;

    // ****************************************
    // field positions
    // ****************************************
    localparam int unsigned CMD_OP_LSB = 0;
    localparam int unsigned CMD_BIT_LSB = 4;
    localparam int unsigned ST_ZERO_BIT = 0;
    localparam int unsigned ST_TIMEOUT_BIT = 1;
    localparam int unsigned ST_POWERDOWN_BIT = 2;
    localparam int unsigned ST_BUSY_BIT = 3;

    // ****************************************
    // reset values
    // ****************************************
    localparam logic [7:0] ACC_RST = 8'h00;
    localparam logic [PC_W-1:0] PC_RST = 11'h000;
    localparam logic [7:0] WATCHDOG_RST = 8'h00;

    // ****************************************
    // instruction codes written to the command register
    // ****************************************
    typedef enum logic [3:0] {
        OP_NOP = 4'h0,
        OP_CONJ_ACC_MEM = 4'h1,
        OP_CONJ_ACC_IMM = 4'h2,
        OP_CONJ_INTO_MEMORY = 4'h3,
        OP_CALL = 4'h4,
        OP_CLEAR_MEM = 4'h5,
        OP_CLEAR_BIT = 4'h6,
        OP_WATCHDOG_SINGLE_CLEAR = 4'h7,
        OP_WATCHDOG_PRECLEAR_FIRST = 4'h8,
        OP_WATCHDOG_PRECLEAR_SECOND = 4'h9,
        OP_INVERT_MEMORY_BYTE = 4'ha
    } lcce_op_t;

    // which preclear ran last, for pairing
    typedef enum logic [1:0] {
        PRE_NONE,
        PRE_FIRST,
        PRE_SECOND
    } lcce_pre_t;

endpackage : lcce_pkg

/* verif/lcce_exec_properties.sv */
// assertion checker for the execution unit bus handshake and instruction timing
module lcce_exec_checker
    import lcce_pkg::*;
(
    input wire logic core_clk,
    input wire logic reset,
    input wire logic clk_en,
    input wire logic [lcce_pkg::AVS_AW-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic exec_busy
);
    // ****************
    // helper logic
    // ****************
    logic [MEM_AW-1:0] opnd_q;
    logic [MEM_AW-1:0] opnd_d;
    logic cmd_go;
    logic pcl_hit;

    // a command counts only on the completing edge of a write made while idle
    assign cmd_go = avs_write && !avs_waitrequest && !exec_busy && avs_byteenable[0]
        && (avs_address == OFS_COMMAND);
    // only memory-writing ops aimed at the low pc byte pay the penalty
    assign pcl_hit = (opnd_q == PCL_MEM_ADDR) && (avs_writedata[3:0] inside
        {OP_CONJ_INTO_MEMORY, OP_CLEAR_MEM, OP_CLEAR_BIT, OP_INVERT_MEMORY_BYTE});

    // shadow of the operand address, since the busy unit ignores late writes
    always_comb
    begin
        opnd_d = opnd_q;
        if (avs_write && !avs_waitrequest && !exec_busy && avs_address == OFS_OPERAND)
            opnd_d = avs_writedata[MEM_AW-1:0];
    end
    always_ff @(posedge core_clk)
    begin
        if (reset)
            opnd_q <= '0;
        else if (clk_en)
            opnd_q <= opnd_d;
    end

    // ****************
    // properties
    // ****************
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);

    property p_plain_len;
        cmd_go && avs_writedata[3:0] != OP_CALL && !pcl_hit |=> exec_busy [*4] ##1 !exec_busy;
    endproperty
    a_plain_len: assert property (p_plain_len) else $error("plain op busy length");
    property p_call_len;
        cmd_go && avs_writedata[3:0] == OP_CALL |=> exec_busy [*8] ##1 !exec_busy;
    endproperty
    a_call_len: assert property (p_call_len) else $error("call busy length");
    property p_pcl_len;
        cmd_go && pcl_hit |=> exec_busy [*8] ##1 !exec_busy;
    endproperty
    a_pcl_len: assert property (p_pcl_len) else $error("low pc write busy length");
    property p_busy_cause;
        $rose(exec_busy) |-> $past(cmd_go);
    endproperty
    a_busy_cause: assert property (p_busy_cause) else $error("busy without command");
    property p_wait_one;
        $rose(avs_read || avs_write) |=> !avs_waitrequest;
    endproperty
    a_wait_one: assert property (p_wait_one) else $error("answer not after one wait");
    property p_wait_pulse;
        !avs_waitrequest |=> avs_waitrequest;
    endproperty
    a_wait_pulse: assert property (p_wait_pulse) else $error("waitrequest low too long");
    property p_idle_wait;
        !avs_read && !avs_write |-> avs_waitrequest;
    endproperty
    a_idle_wait: assert property (p_idle_wait) else $error("waitrequest low while idle");
    property p_unmapped;
        avs_read && !avs_waitrequest && avs_address > OFS_STACK_TOP
            && avs_address < OFS_MEM_BASE |-> avs_readdata == 32'h0000_0000;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_narrow;
        avs_read && !avs_waitrequest && avs_address < OFS_MEM_BASE |-> avs_readdata[31:11] == '0;
    endproperty
    a_narrow: assert property (p_narrow) else $error("register upper bits not zero");
endmodule : lcce_exec_checker

bind lcce_exec lcce_exec_checker lcce_exec_checker_inst (.core_clk(core_clk), .reset(reset),
    .clk_en(clk_en), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .exec_busy(exec_busy));

/* verif/test_lcce_exec.sv */
// self-checking testbench of the execution unit
module test_lcce_exec;
    timeunit 1ns;
    timeprecision 1ps;
    import lcce_pkg::*;

    // ****************
    // signals
    // ****************
    localparam logic [31:0] ALL = 32'hffff_ffff;
    logic core_clk;
    logic reset = 1'b1;
    logic clk_en = 1'b1;
    logic [8:0] avs_address = 9'h000;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0000_0000;
    logic [3:0] avs_byteenable = 4'hf;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic exec_busy;
    int n_errors = 0;
    int checked = 0;
    int cycles = 0;

    lcce_exec lcce_exec_inst (.core_clk(core_clk), .reset(reset), .clk_en(clk_en),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .exec_busy(exec_busy));

    // 250 MHz clock
    initial
    begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end

    // hang guard, the whole run needs only a few thousand cycles
    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles > 20000)
        begin
            n_errors++;
            $display("[ERR] %0t timeout", $time);
            results();
        end
    end

    // ****************
    // tasks
    // ****************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic results();
        $display("checks %0d errors %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : results

    // waitrequest is looked at mid-cycle where it has settled; the request drops
    // at the completing edge and one idle edge follows
    task automatic bus_wr(input logic [8:0] a, input logic [31:0] d);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= 1'b1;
        do @(negedge core_clk); while (avs_waitrequest !== 1'b0);
        @(posedge core_clk);
        avs_write <= 1'b0;
        @(posedge core_clk);
    endtask : bus_wr

    task automatic bus_rd(input logic [8:0] a, output logic [31:0] d);
        avs_address <= a;
        avs_read <= 1'b1;
        do @(negedge core_clk); while (avs_waitrequest !== 1'b0);
        @(posedge core_clk);
        d = avs_readdata;
        avs_read <= 1'b0;
        @(posedge core_clk);
    endtask : bus_rd

    task automatic rd_chk(input logic [8:0] a, input logic [31:0] mask, input logic [31:0] exp);
        logic [31:0] d;
        bus_rd(a, d);
        check(d & mask, exp);
    endtask : rd_chk

    function automatic logic [8:0] ma(input logic [5:0] a);
        return OFS_MEM_BASE | {1'b0, a, 2'b00};
    endfunction : ma

    // issue one instruction and measure how many cycles busy stands
    task automatic run(input logic [3:0] op, input logic [10:0] opnd, input logic [2:0] bi,
        input int n_exp);
        int n;
        n = 1;
        bus_wr(OFS_OPERAND, {21'h000000, opnd});
        bus_wr(OFS_COMMAND, {25'h0000000, bi, op});
        forever
        begin
            #1;
            if (exec_busy !== 1'b1)
                break;
            n++;
            @(posedge core_clk);
        end
        @(posedge core_clk);
        check(32'(n), 32'(n_exp));
    endtask : run

    // ****************
    // scenarios
    // ****************
    task automatic t_reset();
        rd_chk(OFS_ACC, ALL, 32'h0);
        rd_chk(OFS_PC, ALL, 32'h0);
        rd_chk(OFS_STACK_PTR, ALL, 32'h0);
        rd_chk(OFS_STATUS, 32'h7, 32'h0);
        bus_wr(9'h020, 32'h0000_00ff);
        rd_chk(9'h020, ALL, 32'h0);
        $display("test reset done");
    endtask : t_reset

    task automatic t_conj();
        bus_wr(OFS_ACC, 32'h0000_00f0);
        bus_wr(ma(6'h05), 32'h0000_003c);
        run(OP_CONJ_ACC_MEM, 11'h005, 3'h0, 4);
        rd_chk(OFS_ACC, ALL, 32'h30);
        rd_chk(OFS_STATUS, 32'h1, 32'h0);
        run(OP_CONJ_ACC_IMM, 11'h00f, 3'h0, 4);
        rd_chk(OFS_ACC, ALL, 32'h0);
        rd_chk(OFS_STATUS, 32'h1, 32'h1);
        bus_wr(OFS_ACC, 32'h0000_005a);
        bus_wr(ma(6'h06), 32'h0000_00a5);
        run(OP_CONJ_INTO_MEMORY, 11'h006, 3'h0, 4);
        rd_chk(ma(6'h06), ALL, 32'h0);
        rd_chk(OFS_ACC, ALL, 32'h5a);
        $display("test conjunction done");
    endtask : t_conj

    // zero is set before clear bit and cleared before clear memory so a flag update would show
    task automatic t_clear();
        bus_wr(ma(6'h09), 32'h0000_00ff);
        run(OP_INVERT_MEMORY_BYTE, 11'h009, 3'h0, 4);
        rd_chk(ma(6'h09), ALL, 32'h0);
        rd_chk(OFS_STATUS, 32'h1, 32'h1);
        for (int i = 0; i < 8; i++)
        begin
            bus_wr(ma(6'h07), 32'h0000_00ff);
            run(OP_CLEAR_BIT, 11'h007, i[2:0], 4);
            rd_chk(ma(6'h07), ALL, 32'hff & ~(32'h1 << i));
        end
        rd_chk(OFS_STATUS, 32'h1, 32'h1);
        run(OP_INVERT_MEMORY_BYTE, 11'h009, 3'h0, 4);
        rd_chk(ma(6'h09), ALL, 32'hff);
        bus_wr(ma(6'h08), 32'h0000_0077);
        run(OP_CLEAR_MEM, 11'h008, 3'h0, 4);
        rd_chk(ma(6'h08), ALL, 32'h0);
        rd_chk(OFS_STATUS, 32'h1, 32'h0);
        run(OP_CLEAR_MEM, 11'h002, 3'h0, 8);
        run(OP_CONJ_ACC_MEM, 11'h002, 3'h0, 4);
        $display("test clear done");
    endtask : t_clear

    task automatic t_call();
        logic [31:0] p;
        run(OP_CONJ_ACC_IMM, 11'h000, 3'h0, 4);
        for (int i = 0; i < 5; i++)
        begin
            bus_rd(OFS_PC, p);
            run(OP_CALL, 11'h123 + 11'(i), 3'h0, 8);
            rd_chk(OFS_STACK_TOP, ALL, p + 32'h1);
            rd_chk(OFS_PC, ALL, 32'h123 + 32'(i));
            rd_chk(OFS_STACK_PTR, ALL, 32'((i + 1) % 4));
        end
        rd_chk(OFS_STATUS, 32'h1, 32'h1);
        $display("test call done");
    endtask : t_call

    // powerdown is set by software so each clear is visible
    // the counter is left to wrap first so that clearing timeout is visible too
    task automatic t_wdt();
        logic [31:0] d, e;
        repeat (1100) @(posedge core_clk);
        rd_chk(OFS_STATUS, 32'h2, 32'h2);
        bus_wr(OFS_STATUS, 32'h4);
        run(OP_WATCHDOG_SINGLE_CLEAR, 11'h000, 3'h0, 4);
        rd_chk(OFS_STATUS, 32'h6, 32'h0);
        bus_rd(OFS_WATCHDOG, d);
        check(32'(d < 32'h10), 32'h1);
        bus_wr(OFS_STATUS, 32'h4);
        run(OP_WATCHDOG_PRECLEAR_FIRST, 11'h000, 3'h0, 4);
        rd_chk(OFS_STATUS, 32'h4, 32'h4);
        run(OP_WATCHDOG_PRECLEAR_SECOND, 11'h000, 3'h0, 4);
        rd_chk(OFS_STATUS, 32'h6, 32'h0);
        bus_wr(OFS_STATUS, 32'h4);
        run(OP_NOP, 11'h000, 3'h0, 4);
        run(OP_WATCHDOG_PRECLEAR_SECOND, 11'h000, 3'h0, 4);
        rd_chk(OFS_STATUS, 32'h4, 32'h4);
        run(OP_WATCHDOG_PRECLEAR_FIRST, 11'h000, 3'h0, 4);
        rd_chk(OFS_STATUS, 32'h6, 32'h0);
        bus_wr(OFS_STATUS, 32'h4);
        run(OP_WATCHDOG_PRECLEAR_SECOND, 11'h000, 3'h0, 4);
        rd_chk(OFS_STATUS, 32'h4, 32'h4);
        // a frozen unit must not count, so the watchdog barely moves across the stall
        bus_rd(OFS_WATCHDOG, d);
        clk_en <= 1'b0;
        repeat (100) @(posedge core_clk);
        clk_en <= 1'b1;
        bus_rd(OFS_WATCHDOG, e);
        check(32'((e[7:0] - d[7:0]) < 8'h08), 32'h1);
        $display("test watchdog done");
    endtask : t_wdt

    // ****************
    // main sequence
    // ****************
    initial
    begin
        repeat (10) @(posedge core_clk);
        reset <= 1'b0;
        @(posedge core_clk);
        t_reset();
        t_conj();
        t_clear();
        t_call();
        t_wdt();
        results();
    end
endmodule : test_lcce_exec
